// *** design/branch_exec_cfg.svh ***
`ifndef BRANCH_EXEC_CFG_SVH
`define BRANCH_EXEC_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PC_W 21
`define DADDR_W 12
`define IWORD_W 16

// ----------------------------------------------------------------
// Opcode patterns and fields
// ----------------------------------------------------------------
`define OPC_JUMP5 5'h1A
`define OPC_BITSET4 4'h8
`define OPC_SKIP_LOW4 4'hB
`define OPC_SKIP_HIGH4 4'hA
`define NOP_WORD 16'h0000
`define FLD_BIT_HI 11
`define FLD_BIT_LO 9
`define FLD_ACCESS 8

// ----------------------------------------------------------------
// Data addressing
// ----------------------------------------------------------------
`define ACC_SPLIT 8'h60
`define IDX_LIMIT 8'h5F
`define SFR_PAGE 4'hF
`define LOW_PAGE 4'h0

// ----------------------------------------------------------------
// Reset values and steps
// ----------------------------------------------------------------
`define PC_RESET 21'h0_0000
`define PC_STEP 21'h0_0002
`define DADDR_RESET 12'h000
`define DATA_RESET 8'h00

`endif

// *** design/branch_exec_pkg.sv ***
`include "branch_exec_cfg.svh"

package branch_exec_pkg;

    typedef logic [`PC_W-1:0] pc_t;
    typedef logic [`DADDR_W-1:0] daddr_t;
    typedef logic [`IWORD_W-1:0] iword_t;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

    typedef enum logic [2:0] {
        EX_NOP,
        EX_JUMP,
        EX_BITSET,
        EX_SKIP_LOW,
        EX_SKIP_HIGH
    } exec_kind_t;

endpackage : branch_exec_pkg

// *** design/quarter_phase_gen.sv ***
`timescale 1ns/1ps

module quarter_phase_gen
    import branch_exec_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst_n, // Synchronised reset
    output branch_exec_pkg::phase_t phase // Current quarter
);
    import branch_exec_pkg::*;

    phase_t phase_q;
    phase_t phase_d;

    always_comb
    begin
        case (phase_q)
            PH_Q1: phase_d = PH_Q2;
            PH_Q2: phase_d = PH_Q3;
            PH_Q3: phase_d = PH_Q4;
            PH_Q4: phase_d = PH_Q1;
            default: phase_d = PH_Q1;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_q <= PH_Q1;
        else
            phase_q <= phase_d;
    end

    assign phase = phase_q;

endmodule : quarter_phase_gen

// *** design/branch_bitset_skip_exec.sv ***
// Function
// - Relative jump sets PC to incremented PC plus twice signed offset.
// - Jump decoded from top opcode bits 1101 then 0, eleven offset bits.
// - Jump takes two cycles; PC written in Q4, second cycle no-op.
// - Bit force sets chosen bit of file register, others unchanged.
// - Bit force decoded by top nibble 1000, bit index, access, address.
// - Access bit 0 picks access bank; 1 uses bank pointer.
// - Access 0, extended set on, address up to 95: indexed offset mode.
// - Test-skip-when-high skips next instruction if tested bit is one.
// - Taken skip discards fetched word and runs a no-op instead.
`timescale 1ns/1ps
`include "branch_exec_cfg.svh"

module branch_bitset_skip_exec
    import branch_exec_pkg::*;
(
    input wire logic clk, // Core clock, 100 MHz
    input wire logic arst_n, // Async reset, active low
    input branch_exec_pkg::iword_t fetch_word, // Word at fetch_addr
    output branch_exec_pkg::pc_t fetch_addr, // Program counter
    input wire logic [3:0] bank_pointer_reg, // Bank select value
    input wire logic ext_set_en, // Extended set enabled
    input branch_exec_pkg::daddr_t index_base, // Indexed mode base
    output branch_exec_pkg::daddr_t mem_addr, // Data memory address
    output logic mem_rd, // Read strobe, Q2
    input wire logic [7:0] mem_rdata, // Read data
    output logic mem_wr, // Write strobe, Q4
    output logic [7:0] mem_wdata, // Write data
    output branch_exec_pkg::phase_t q_phase // Current quarter
);
    import branch_exec_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    phase_t phase;

    quarter_phase_gen u_phase (
        .clk(clk),
        .rst_n(rst_n),
        .phase(phase)
    );

    // ----------------------------------------------------------------
    // Decode and address helpers
    // ----------------------------------------------------------------
    function automatic exec_kind_t decode_kind(input iword_t w);
        exec_kind_t k;
        k = EX_NOP;
        if (w[15:11] == `OPC_JUMP5)
            k = EX_JUMP;
        else if (w[15:12] == `OPC_BITSET4)
            k = EX_BITSET;
        else if (w[15:12] == `OPC_SKIP_LOW4)
            k = EX_SKIP_LOW;
        else if (w[15:12] == `OPC_SKIP_HIGH4)
            k = EX_SKIP_HIGH;
        return k;
    endfunction : decode_kind

    function automatic daddr_t data_addr(input logic acc, input logic [7:0] f,
                                         input logic ext,
                                         input logic [3:0] bank,
                                         input daddr_t base);
        daddr_t a;
        if (acc)
            a = {bank, f};
        else if (ext && f <= `IDX_LIMIT)
            a = base + {4'h0, f};
        else if (f < `ACC_SPLIT)
            a = {`LOW_PAGE, f};
        else
            a = {`SFR_PAGE, f};
        return a;
    endfunction : data_addr

    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        return 8'h01 << b;
    endfunction : bit_mask

    function automatic pc_t jump_delta(input iword_t w);
        // Offset doubled: word-aligned targets only
        return {{9{w[10]}}, w[10:0], 1'b0};
    endfunction : jump_delta

    // ----------------------------------------------------------------
    // Execution state
    // ----------------------------------------------------------------
    pc_t pc_q, pc_d;
    iword_t ir_q, ir_d;
    exec_kind_t kind_q, kind_d;
    logic [2:0] bit_q, bit_d;
    daddr_t addr_q, addr_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] wdata_q, wdata_d;
    logic skip_q, skip_d;
    logic is_file_op;

    assign is_file_op = kind_q == EX_BITSET || kind_q == EX_SKIP_LOW ||
                        kind_q == EX_SKIP_HIGH;
    assign mem_rd = phase == PH_Q2 && is_file_op;
    assign mem_wr = phase == PH_Q4 && kind_q == EX_BITSET;

    always_comb
    begin
        pc_d = pc_q;
        ir_d = ir_q;
        kind_d = kind_q;
        bit_d = bit_q;
        addr_d = addr_q;
        rdata_d = rdata_q;
        wdata_d = wdata_q;
        skip_d = skip_q;
        case (phase)
            PH_Q1:
            begin
                kind_d = decode_kind(ir_q);
                bit_d = ir_q[`FLD_BIT_HI:`FLD_BIT_LO];
                addr_d = data_addr(ir_q[`FLD_ACCESS], ir_q[7:0], ext_set_en,
                                   bank_pointer_reg, index_base);
                skip_d = 1'b0;
            end
            PH_Q2:
            begin
                if (mem_rd)
                    rdata_d = mem_rdata;
            end
            PH_Q3:
            begin
                wdata_d = rdata_q | bit_mask(bit_q);
                skip_d = (kind_q == EX_SKIP_HIGH && rdata_q[bit_q]) ||
                         (kind_q == EX_SKIP_LOW && !rdata_q[bit_q]);
            end
            PH_Q4:
            begin
                pc_d = pc_q + `PC_STEP;
                ir_d = fetch_word;
                if (kind_q == EX_JUMP)
                begin
                    // Prefetched word is stale after a jump
                    pc_d = pc_q + jump_delta(ir_q);
                    ir_d = `NOP_WORD;
                end
                else if (skip_q)
                    ir_d = `NOP_WORD;
            end
            default:
            begin
                skip_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_q <= `PC_RESET;
            ir_q <= `NOP_WORD;
            kind_q <= EX_NOP;
            bit_q <= 3'h0;
            addr_q <= `DADDR_RESET;
            rdata_q <= `DATA_RESET;
            wdata_q <= `DATA_RESET;
            skip_q <= 1'b0;
        end
        else
        begin
            pc_q <= pc_d;
            ir_q <= ir_d;
            kind_q <= kind_d;
            bit_q <= bit_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
            wdata_q <= wdata_d;
            skip_q <= skip_d;
        end
    end

    assign fetch_addr = pc_q;
    assign mem_addr = addr_q;
    assign mem_wdata = wdata_q;
    assign q_phase = phase;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_jump_target: assert property (
        phase == PH_Q4 && kind_q == EX_JUMP |=>
            pc_q == $past(pc_q) + {{9{$past(ir_q[10])}}, $past(ir_q[10:0]),
                                   1'b0})
        else $error("jump target wrong");

    a_jump_decode: assert property (
        phase == PH_Q1 && ir_q[15:11] == 5'h1A |=> kind_q == EX_JUMP)
        else $error("jump not decoded");

    a_jump_two_cycles: assert property (
        phase == PH_Q4 && kind_q == EX_JUMP |=> ##1 kind_q == EX_NOP ##2
            pc_q == $past(pc_q, 3))
        else $error("jump second cycle not idle");

    a_bitset_value: assert property (
        mem_wr |-> (mem_wdata & ~bit_mask(bit_q)) ==
                   (rdata_q & ~bit_mask(bit_q)) &&
                   (mem_wdata & bit_mask(bit_q)) != 8'h00)
        else $error("bit force data wrong");

    a_bitset_decode: assert property (
        phase == PH_Q1 && ir_q[15:12] == 4'h8 |=>
            kind_q == EX_BITSET && bit_q == $past(ir_q[11:9]))
        else $error("bit force not decoded");

    a_bank_select: assert property (
        phase == PH_Q1 && ir_q[8] |=>
            mem_addr == {$past(bank_pointer_reg), $past(ir_q[7:0])})
        else $error("banked address wrong");

    a_indexed_mode: assert property (
        phase == PH_Q1 && !ir_q[8] && ext_set_en && ir_q[7:0] <= 8'h5F |=>
            mem_addr == $past(index_base) + {4'h0, $past(ir_q[7:0])})
        else $error("indexed address wrong");

    a_bitset_quarters: assert property (
        mem_rd && kind_q == EX_BITSET |-> ##2 mem_wr && !mem_rd)
        else $error("bit force quarters wrong");

    a_skip_high: assert property (
        phase == PH_Q3 && kind_q == EX_SKIP_HIGH && rdata_q[bit_q] |=>
            skip_q ##1 ir_q == 16'h0000)
        else $error("skip on set bit missed");

    a_skip_nop: assert property (
        phase == PH_Q4 && skip_q |=> ir_q == 16'h0000 ##1 kind_q == EX_NOP)
        else $error("skipped word not discarded");

    c_jump: cover property (phase == PH_Q4 && kind_q == EX_JUMP);
    c_bitset: cover property (mem_wr);
    c_skip_high: cover property (phase == PH_Q4 && skip_q &&
                                 kind_q == EX_SKIP_HIGH);
    c_skip_low: cover property (phase == PH_Q4 && skip_q &&
                                kind_q == EX_SKIP_LOW);

endmodule : branch_bitset_skip_exec

// *** verification/tb_branch_bitset_skip_exec.sv ***
`timescale 1ns/1ps
`include "branch_exec_cfg.svh"

module tb_branch_bitset_skip_exec;
    import branch_exec_pkg::*;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    iword_t fetch_word;
    pc_t fetch_addr;
    logic [3:0] bank_pointer_reg = 4'h0;
    logic ext_set_en = 1'b1;
    daddr_t index_base = 12'h000;
    daddr_t mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_rdata;
    logic [7:0] mem_wdata;
    phase_t q_phase;
    iword_t prog [251];
    logic [7:0] dmem [4096];
    int seed = 4927;
    int errors = 0;
    int samples_checked = 0;

    always #5 clk = ~clk;

    // Odd program size; a jump whose offset plus one is a multiple of 251 still aliases onto itself
    function automatic int pix(input pc_t p);
        return int'(p[20:1] % 251);
    endfunction : pix

    assign fetch_word = prog[pix(fetch_addr)];
    assign mem_rdata = dmem[mem_addr];

    branch_bitset_skip_exec dut (
        .clk(clk),
        .arst_n(arst_n),
        .fetch_word(fetch_word),
        .fetch_addr(fetch_addr),
        .bank_pointer_reg(bank_pointer_reg),
        .ext_set_en(ext_set_en),
        .index_base(index_base),
        .mem_addr(mem_addr),
        .mem_rd(mem_rd),
        .mem_rdata(mem_rdata),
        .mem_wr(mem_wr),
        .mem_wdata(mem_wdata),
        .q_phase(q_phase)
    );

    // ----------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------
    function automatic daddr_t ea_f(input iword_t w, input logic x,
                                    input logic [3:0] bk, input daddr_t bs);
        logic [7:0] f;
        f = w[7:0];
        if (w[`FLD_ACCESS])
            return {bk, f};
        if (x && f <= `IDX_LIMIT)
            return bs + {4'h0, f};
        if (f < `ACC_SPLIT)
            return {`LOW_PAGE, f};
        return {`SFR_PAGE, f};
    endfunction : ea_f

    function automatic iword_t rand_word();
        logic [15:0] r;
        r = 16'($random(seed));
        case (r[15:13])
            // Offset -1 would jump onto itself forever
            3'h0, 3'h1:
                return {`OPC_JUMP5,
                        (r[10:0] == 11'h7FF) ? 11'h000 : r[10:0]};
            3'h2, 3'h3: return {`OPC_BITSET4, r[11:0]};
            3'h4: return {`OPC_SKIP_HIGH4, r[11:0]};
            3'h5: return {`OPC_SKIP_LOW4, r[11:0]};
            3'h6: return `NOP_WORD;
            default: return 16'($random(seed));
        endcase
    endfunction : rand_word

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        #300_000;
        errors++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Main sequence: lock-step model, one pass per instruction cycle
    // ----------------------------------------------------------------
    initial
    begin
        pc_t pc;
        iword_t ir;
        daddr_t ea;
        logic rd_e, wr_e, jmp, skh, skl, take, cx;
        logic [7:0] rv;
        logic [2:0] b;
        logic [3:0] cbk;
        daddr_t cbs;
        int k;
        for (k = 0; k < 251; k++)
            prog[k] = rand_word();
        for (k = 0; k < 4096; k++)
            dmem[k] = 8'($random(seed));
        prog[0] = 16'h8E5F;
        prog[1] = 16'h8060;
        prog[2] = 16'h87FF;
        prog[3] = 16'hAE00;
        prog[4] = 16'hB100;
        prog[5] = 16'hD400;
        prog[6] = 16'hD3FF;
        repeat (4) @(posedge clk);
        #1 arst_n = 1'b1;
        k = 0;
        while (q_phase !== PH_Q4 && k < 20)
        begin
            @(posedge clk);
            #1 k++;
        end
        pc = `PC_RESET;
        ir = `NOP_WORD;
        {rd_e, wr_e, jmp, take} = 4'h0;
        for (k = 0; k < 2000; k++)
        begin
            check(q_phase, PH_Q4);
            check(mem_wr, wr_e);
            if (wr_e)
            begin
                check(mem_wdata, rv | (8'h01 << b));
                dmem[ea] = rv | (8'h01 << b);
            end
            if (jmp)
                pc = pc + {{9{ir[10]}}, ir[10:0], 1'b0};
            else
                pc = pc + `PC_STEP;
            ir = (jmp || take) ? `NOP_WORD : prog[pix(pc - `PC_STEP)];
            {cx, cbk, cbs} = {ext_set_en, bank_pointer_reg, index_base};
            @(posedge clk);
            #1 check(fetch_addr, pc);
            check(mem_rd, 1'b0);
            jmp = ir[15:11] == `OPC_JUMP5;
            wr_e = ir[15:12] == `OPC_BITSET4;
            skh = ir[15:12] == `OPC_SKIP_HIGH4;
            skl = ir[15:12] == `OPC_SKIP_LOW4;
            rd_e = wr_e | skh | skl;
            b = ir[`FLD_BIT_HI:`FLD_BIT_LO];
            ea = ea_f(ir, cx, cbk, cbs);
            @(posedge clk);
            #1 check(mem_rd, rd_e);
            check(mem_wr, 1'b0);
            if (rd_e)
                check(mem_addr, ea);
            rv = dmem[ea];
            take = (skh & rv[b]) | (skl & ~rv[b]);
            @(posedge clk);
            #1 check(mem_rd, 1'b0);
            bank_pointer_reg = 4'($random(seed));
            ext_set_en = (k < 8) ? 1'b1 : 1'($random(seed));
            index_base = 12'($random(seed));
            @(posedge clk);
            #1;
            if (k == 16)
                $display("corner program done, checks=%0d", samples_checked);
        end
        $display("random program done, checks=%0d", samples_checked);
        print_verdict();
    end

endmodule : tb_branch_bitset_skip_exec
